// *** include/sac_pkg.sv ***
package sac_pkg;
   // ------------------------------------------------------------
   // register byte addresses
   // ------------------------------------------------------------
   localparam logic [7:0] ADDR_P2CFG = 8'h9e;  // port two analog config
   localparam logic [7:0] ADDR_CTRL  = 8'hd2;  // converter control
   localparam logic [7:0] ADDR_RESH  = 8'hd3;  // result high byte
   localparam logic [7:0] ADDR_RESL  = 8'hd4;  // result low and clock cfg
   localparam logic [7:0] ADDR_REF   = 8'hd5;  // reference select
   localparam logic [7:0] ADDR_P1CFG = 8'hd6;  // port one analog config
   localparam logic [7:0] ADDR_INTERRUPT_ENABLE_PRIMARY  = 8'ha8;  // irq enable primary
   localparam logic [7:0] ADDR_INTERRUPT_ENABLE_SECONDARY  = 8'h9a;  // irq enable secondary
   localparam logic [7:0] ADDR_IRF2  = 8'hbf;  // irq flags secondary
   // ------------------------------------------------------------
   // field positions
   // ------------------------------------------------------------
   localparam int BIT_EN    = 7;  // converter_enable
   localparam int BIT_START = 6;  // conversion_start
   localparam int BIT_EOC   = 5;  // completion flag
   localparam int BIT_GATE  = 6;  // global_channel_gate
   localparam int BIT_CKLO  = 4;  // converter_clock_divider low bit
   localparam int BIT_EXTR  = 7;  // external_reference_enable
   localparam int BIT_PWM   = 4;  // pwm_trigger_enable
   localparam int BIT_OVR   = 2;  // reference_supply_override
   localparam int BIT_GIE   = 7;  // global irq enable
   localparam int BIT_IEN   = 1;  // converter_irq_enable
   localparam int BIT_IRF   = 0;  // converter_irq_flag
   // ------------------------------------------------------------
   // channel codes, reset values and timing
   // ------------------------------------------------------------
   localparam logic [3:0] CH_OPAMP = 4'hb;  // opamp_output_channel
   localparam logic [3:0] CH_FIXED = 4'hc;  // internal_fixed_channel
   localparam logic [1:0] LVL_VDD  = 2'h3;  // internal level = supply
   localparam logic [7:0] RST_BYTE = 8'h00; // reset of all control bits
   localparam int CONV_PERIODS = 16;         // quarter-rate periods
   localparam int CONV_QUARTER = 4;          // converter clocks per period
   localparam int CONV_TICKS   = CONV_PERIODS * CONV_QUARTER;
   // ------------------------------------------------------------
   // carriers
   // ------------------------------------------------------------
   typedef struct packed {
      logic [7:0] addr;   // register address
      logic [7:0] wdata;  // write data
      logic       wr;     // write strobe
      logic       rd;     // read strobe
   } sac_bus_t;
   typedef struct packed {
      logic        power_en;    // core powered
      logic [10:0] pin_sel;     // external inputs 0..10
      logic        opamp_sel;   // amplifier output routed
      logic        fixed_sel;   // internal fixed channel routed
      logic        ext_ref_en;  // high reference from pin
      logic [1:0]  ref_level;   // internal level code
      logic [6:0]  p1_pure;     // port one pins 7..1 isolated
      logic [5:0]  p2_pure;     // port two pins 5..0 isolated
      logic        conv_active; // sample/convert in progress
      logic        clk_tick;    // converter clock enable
   } sac_ana_t;
endpackage

// *** rtl/sac_top.sv ***
// Added by the designer: the strobed register port.
`timescale 1ns/1ns
module sac_top (
   input  wire logic              clk,        // 250 MHz system clock
   input  wire logic              rst_n,      // async reset, active low
   input  wire sac_pkg::sac_bus_t bus,        // register port
   output logic [7:0]             rdata,      // read data, cycle after rd
   input  wire logic              pwm_trig,   // pwm start event pulse
   input  wire logic [11:0]       core_result,// result from analog core
   output sac_pkg::sac_ana_t      ana,        // controls to analog core
   output logic                   irq_req     // request to irq controller
);
   import sac_pkg::*;

   // ------------------------------------------------------------
   // reset release
   // ------------------------------------------------------------
   logic [1:0] rst_sync;  // two-stage release
   logic       rst_ok_n;  // synchronised reset used by every flop but rst_sync and result

   // release through two flops so all flops on rst_ok_n leave reset together
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_sync <= 2'h0;
      end else begin
         rst_sync <= {rst_sync[0], 1'b1};
      end
   end
   assign rst_ok_n = rst_sync[1];

   // ------------------------------------------------------------
   // divider helpers
   // ------------------------------------------------------------
   // system clocks per converter clock for a divider code
   function automatic logic [4:0] div_of(input logic [1:0] code);
      case (code)
         2'h0:    div_of = 5'h10;  // fosc/16
         2'h1:    div_of = 5'h08;  // fosc/8
         2'h2:    div_of = 5'h01;  // fosc/1
         default: div_of = 5'h02;  // fosc/2
      endcase
   endfunction

   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   logic        en;        // converter_enable
   logic        busy;      // conversion_start, held until done or enable cleared
   logic        eoc;       // completion flag
   logic [3:0]  chs;       // input_channel_select
   logic        rsv7;      // spare read/write bit of low result reg
   logic        gate;      // global_channel_gate
   logic [1:0]  ckdiv;     // converter_clock_divider
   logic        ext_ref;   // external_reference_enable
   logic        pwm_en;    // pwm_trigger_enable
   logic        ovr;       // reference_supply_override
   logic [1:0]  lvl;       // internal_reference_level
   logic [6:0]  p1cfg;     // port_one_analog_cfg bits 7..1
   logic [5:0]  p2cfg;     // port_two_analog_cfg bits 5..0
   logic        gie;       // global irq enable, stored only
   logic        irq_en;    // converter_irq_enable
   logic        irq_flag;  // converter_irq_flag
   logic [11:0] result;    // converted value, no reset
   logic [1:0]  run_div;   // divider code frozen at start
   logic [4:0]  dcnt;      // system clocks within converter clock
   logic [5:0]  tcnt;      // converter clocks within conversion

   // ------------------------------------------------------------
   // address decode
   // ------------------------------------------------------------
   wire wr_ctl  = bus.wr && (bus.addr == ADDR_CTRL);
   wire wr_resl = bus.wr && (bus.addr == ADDR_RESL);
   wire wr_ref  = bus.wr && (bus.addr == ADDR_REF);
   wire wr_p1   = bus.wr && (bus.addr == ADDR_P1CFG);
   wire wr_p2   = bus.wr && (bus.addr == ADDR_P2CFG);
   wire wr_interrupt_enable_primary = bus.wr && (bus.addr == ADDR_INTERRUPT_ENABLE_PRIMARY);
   wire wr_interrupt_enable_secondary = bus.wr && (bus.addr == ADDR_INTERRUPT_ENABLE_SECONDARY);
   wire wr_irf  = bus.wr && (bus.addr == ADDR_IRF2);

   // ------------------------------------------------------------
   // conversion sequencing
   // ------------------------------------------------------------
   wire [4:0] run_len  = div_of(run_div);
   // one converter clock elapsed
   wire       tick     = busy && (dcnt == run_len - 5'h1);
   // last of 16 quarter-rate periods
   wire       conv_end = tick && (tcnt == 6'(CONV_TICKS - 1));
   // enable as it stands after this cycle's write
   wire       next_en  = wr_ctl ? bus.wdata[BIT_EN] : en;
   wire       sw_start = wr_ctl && bus.wdata[BIT_START];
   wire       hw_start = pwm_en && pwm_trig;
   // a start is lost, not queued, when disabled or busy
   wire       start_ok = (sw_start || hw_start) && next_en && !busy;
   // clearing enable mid-conversion abandons it without a done flag
   wire       next_busy = start_ok ? 1'b1 :
                          (conv_end || !next_en) ? 1'b0 : busy;
   // done beats a same-cycle software clear
   wire       next_eoc  = conv_end ? 1'b1 :
                          start_ok ? 1'b0 :
                          (wr_ctl && !bus.wdata[BIT_EOC]) ? 1'b0 : eoc;
   wire       next_flag = conv_end ? 1'b1 :
                          wr_irf ? bus.wdata[BIT_IRF] : irq_flag;

   // ------------------------------------------------------------
   // analog-side decode
   // ------------------------------------------------------------
   wire        routed   = gate && (chs <= CH_FIXED);
   wire [10:0] next_pin = (routed && chs < CH_OPAMP) ?
                          (11'h1 << chs) : 11'h0;
   wire        next_opa = routed && (chs == CH_OPAMP);
   wire        next_fix = routed && (chs == CH_FIXED);
   // override forces supply; internal levels stay unused off the pin
   wire [1:0]  next_lvl = ovr ? LVL_VDD : lvl;

   // ------------------------------------------------------------
   // read mux
   // ------------------------------------------------------------
   wire [7:0] rd_ctl  = {en, busy, eoc, 1'b0, chs};
   wire [7:0] rd_resl = {rsv7, gate, ckdiv, result[3:0]};
   wire [7:0] rd_ref  = {ext_ref, 2'h0, pwm_en, 1'b0, ovr, lvl};
   logic [7:0] next_rdata;  // selected byte, zero when unmapped

   always_comb begin
      next_rdata = 8'h00;
      case (bus.addr)
         ADDR_CTRL:  next_rdata = rd_ctl;
         ADDR_RESH:  next_rdata = result[11:4];
         ADDR_RESL:  next_rdata = rd_resl;
         ADDR_REF:   next_rdata = rd_ref;
         ADDR_P1CFG: next_rdata = {p1cfg, 1'b0};
         ADDR_P2CFG: next_rdata = {2'h0, p2cfg};
         ADDR_INTERRUPT_ENABLE_PRIMARY:  next_rdata = {gie, 7'h00};
         ADDR_INTERRUPT_ENABLE_SECONDARY:  next_rdata = {6'h00, irq_en, 1'b0};
         ADDR_IRF2:  next_rdata = {7'h00, irq_flag};
         default:    next_rdata = 8'h00;
      endcase
   end

   // ------------------------------------------------------------
   // control state
   // ------------------------------------------------------------
   // converter control and status
   always_ff @(posedge clk or negedge rst_ok_n) begin
      if (!rst_ok_n) begin
         {en, eoc, chs} <= 6'h00;
         busy           <= 1'b0;
      end else begin
         en   <= next_en;
         busy <= next_busy;
         eoc  <= next_eoc;
         if (wr_ctl) begin
            chs <= bus.wdata[3:0];
         end
      end
   end

   // configuration registers
   always_ff @(posedge clk or negedge rst_ok_n) begin
      if (!rst_ok_n) begin
         {rsv7, gate, ckdiv}          <= 4'h0;
         {ext_ref, pwm_en, ovr, lvl}  <= 5'h00;
         p1cfg                        <= RST_BYTE[7:1];
         p2cfg                        <= RST_BYTE[5:0];
      end else begin
         if (wr_resl) begin
            {rsv7, gate, ckdiv} <= bus.wdata[7:4];
         end
         if (wr_ref) begin
            ext_ref <= bus.wdata[BIT_EXTR];
            pwm_en  <= bus.wdata[BIT_PWM];
            ovr     <= bus.wdata[BIT_OVR];
            lvl     <= bus.wdata[1:0];
         end
         if (wr_p1) begin
            p1cfg <= bus.wdata[7:1];
         end
         if (wr_p2) begin
            p2cfg <= bus.wdata[5:0];
         end
      end
   end

   // interrupt enable and request flag
   always_ff @(posedge clk or negedge rst_ok_n) begin
      if (!rst_ok_n) begin
         {gie, irq_en, irq_flag} <= 3'h0;
      end else begin
         if (wr_interrupt_enable_primary) begin
            gie <= bus.wdata[BIT_GIE];
         end
         if (wr_interrupt_enable_secondary) begin
            irq_en <= bus.wdata[BIT_IEN];
         end
         irq_flag <= next_flag;
      end
   end

   // conversion counters; divider code frozen so a rewrite cannot
   // stretch or cut a conversion already running
   always_ff @(posedge clk or negedge rst_ok_n) begin
      if (!rst_ok_n) begin
         run_div <= 2'h0;
         dcnt    <= 5'h00;
         tcnt    <= 6'h00;
      end else if (start_ok) begin
         run_div <= wr_resl ? bus.wdata[5:4] : ckdiv;
         dcnt    <= 5'h00;
         tcnt    <= 6'h00;
      end else if (busy) begin
         dcnt <= tick ? 5'h00 : dcnt + 5'h1;
         tcnt <= tick ? tcnt + 6'h1 : tcnt;
      end
   end

   // result buffer: deliberately unreset, holds garbage until first done
   always_ff @(posedge clk) begin
      if (conv_end) begin
         result <= core_result;
      end
   end

   // ------------------------------------------------------------
   // registered outputs
   // ------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_ok_n) begin
      if (!rst_ok_n) begin
         rdata   <= 8'h00;
         ana     <= '0;
         irq_req <= 1'b0;
      end else begin
         rdata           <= bus.rd ? next_rdata : 8'h00;
         ana.power_en    <= en;
         ana.pin_sel     <= next_pin;
         ana.opamp_sel   <= next_opa;
         ana.fixed_sel   <= next_fix;
         ana.ext_ref_en  <= ext_ref;
         ana.ref_level   <= next_lvl;
         ana.p1_pure     <= p1cfg;
         ana.p2_pure     <= p2cfg;
         ana.conv_active <= busy;
         ana.clk_tick    <= tick;
         irq_req         <= irq_flag && irq_en;
      end
   end

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   logic [10:0] busy_cnt;  // cycles spent busy, checker helper

   always_ff @(posedge clk or negedge rst_ok_n) begin
      if (!rst_ok_n) begin
         busy_cnt <= 11'h000;
      end else begin
         busy_cnt <= busy ? busy_cnt + 11'h1 : 11'h000;
      end
   end

   property p_start;
      @(posedge clk) disable iff (!rst_ok_n)
      start_ok |=> busy && !eoc;
   endproperty
   a_start: assert property (p_start) else $error("start not taken");

   property p_eoc_low;
      @(posedge clk) disable iff (!rst_ok_n)
      busy |-> !eoc;
   endproperty
   a_eoc_low: assert property (p_eoc_low) else $error("flag high while busy");

   property p_done;
      @(posedge clk) disable iff (!rst_ok_n)
      conv_end |=> eoc && irq_flag && !busy && result == $past(core_result);
   endproperty
   a_done: assert property (p_done) else $error("done edge wrong");

   property p_len;
      @(posedge clk) disable iff (!rst_ok_n)
      conv_end |-> busy_cnt == 11'(CONV_TICKS) * 11'(run_len) - 11'h1;
   endproperty
   a_len: assert property (p_len) else $error("conversion length wrong");

   property p_no_start;
      @(posedge clk) disable iff (!rst_ok_n)
      !busy && !next_en |=> !busy;
   endproperty
   a_no_start: assert property (p_no_start) else $error("start while disabled");

   property p_pwm_off;
      @(posedge clk) disable iff (!rst_ok_n)
      !busy && !pwm_en && !sw_start |=> !busy;
   endproperty
   a_pwm_off: assert property (p_pwm_off) else $error("pwm started conversion");

   property p_pwm_on;
      @(posedge clk) disable iff (!rst_ok_n)
      !busy && en && !bus.wr && pwm_en && pwm_trig |=> busy ##1 ana.conv_active;
   endproperty
   a_pwm_on: assert property (p_pwm_on) else $error("pwm start lost");

   property p_reserved;
      @(posedge clk) disable iff (!rst_ok_n)
      chs > CH_FIXED |=> ana.pin_sel == 11'h0 && !ana.opamp_sel && !ana.fixed_sel;
   endproperty
   a_reserved: assert property (p_reserved) else $error("reserved code routed");

   property p_opamp;
      @(posedge clk) disable iff (!rst_ok_n)
      gate && chs == CH_OPAMP |=> ana.opamp_sel && ana.pin_sel == 11'h0;
   endproperty
   a_opamp: assert property (p_opamp) else $error("amplifier not routed");

   property p_gate;
      @(posedge clk) disable iff (!rst_ok_n)
      !gate |=> ana.pin_sel == 11'h0 && !ana.opamp_sel && !ana.fixed_sel;
   endproperty
   a_gate: assert property (p_gate) else $error("input routed with gate off");

   property p_ovr;
      @(posedge clk) disable iff (!rst_ok_n)
      ovr |=> ana.ref_level == LVL_VDD;
   endproperty
   a_ovr: assert property (p_ovr) else $error("override ignored");

   property p_irq;
      @(posedge clk) disable iff (!rst_ok_n)
      irq_flag && !irq_en |=> !irq_req;
   endproperty
   a_irq: assert property (p_irq) else $error("masked request raised");

   property p_irq_on;
      @(posedge clk) disable iff (!rst_ok_n)
      irq_flag && irq_en |=> irq_req;
   endproperty
   a_irq_on: assert property (p_irq_on) else $error("enabled request lost");

   property p_flag_hold;
      @(posedge clk) disable iff (!rst_ok_n)
      irq_flag && !(wr_irf && !bus.wdata[BIT_IRF]) |=> irq_flag;
   endproperty
   a_flag_hold: assert property (p_flag_hold) else $error("request flag dropped");

   // sticky flag: only a zero write or a fresh start may lower it
   property p_eoc_hold;
      @(posedge clk) disable iff (!rst_ok_n)
      eoc && !start_ok && !(wr_ctl && !bus.wdata[BIT_EOC]) |=> eoc;
   endproperty
   a_eoc_hold: assert property (p_eoc_hold) else $error("done flag dropped");

   property p_abort;
      @(posedge clk) disable iff (!rst_ok_n)
      busy && !next_en && !conv_end |=> !busy && !eoc;
   endproperty
   a_abort: assert property (p_abort) else $error("abort left conversion running");

   property p_pin;
      @(posedge clk) disable iff (!rst_ok_n)
      gate && chs < CH_OPAMP |=> ana.pin_sel == (11'h1 << $past(chs)) && !ana.fixed_sel;
   endproperty
   a_pin: assert property (p_pin) else $error("external input not routed");

   property p_fixed;
      @(posedge clk) disable iff (!rst_ok_n)
      gate && chs == CH_FIXED |=> ana.fixed_sel && !ana.opamp_sel && ana.pin_sel == 11'h0;
   endproperty
   a_fixed: assert property (p_fixed) else $error("fixed channel not routed");

   property p_lvl;
      @(posedge clk) disable iff (!rst_ok_n)
      !ovr |=> ana.ref_level == $past(lvl);
   endproperty
   a_lvl: assert property (p_lvl) else $error("internal level not followed");

   property p_pure;
      @(posedge clk) disable iff (!rst_ok_n)
      1'b1 |=> ana.p1_pure == $past(p1cfg) && ana.p2_pure == $past(p2cfg);
   endproperty
   a_pure: assert property (p_pure) else $error("pure analog bits not passed");

   c_sw_conv:  cover property (@(posedge clk) disable iff (!rst_ok_n)
                               sw_start && start_ok ##[1:300] conv_end);
   c_pwm_conv: cover property (@(posedge clk) disable iff (!rst_ok_n)
                               hw_start && start_ok);
   c_race:     cover property (@(posedge clk) disable iff (!rst_ok_n)
                               conv_end && wr_ctl && !bus.wdata[BIT_EOC]);
   c_abort:    cover property (@(posedge clk) disable iff (!rst_ok_n)
                               busy && wr_ctl && !bus.wdata[BIT_EN]);
endmodule

// *** verification/sac_core_model.sv ***
`timescale 1ns/1ns
module sac_core_model (
   input  wire sac_pkg::sac_ana_t ana,         // controls from the block
   input  wire logic [11:0]       value,       // value to report this time
   output logic [11:0]            core_result  // converter output word
);
   import sac_pkg::*;
   // ------------------------------------------------------------
   // converter core
   // ------------------------------------------------------------
   // the word is only valid while powered and converting; outside that
   // the inverse shows, so a late or early capture cannot pass by chance
   assign core_result = (ana.power_en && ana.conv_active) ? value : ~value;
endmodule

// *** verification/tb_top.sv ***
`timescale 1ns/1ns
module tb_top;
   import sac_pkg::*;
   // ------------------------------------------------------------
   // stimulus and observed signals
   // ------------------------------------------------------------
   logic        clk = 1'b0;         // 250 MHz system clock
   logic        rst_n = 1'b0;       // held low at start
   sac_bus_t    bus = '0;           // register port, idle
   logic        pwm_trig = 1'b0;    // pwm start event
   logic [11:0] core_val = 12'h000; // word the core model reports
   logic [7:0]  rdata;              // read data
   logic [11:0] core_result;        // core model output
   sac_ana_t    ana;                // analog controls
   logic        irq_req;            // interrupt request
   int          num_errors = 0;     // mismatches
   int          tests_run = 0;      // comparisons
   int          cycles = 0;         // hang guard
   always #2 clk = ~clk;
   sac_top u_sac_top (.clk(clk), .rst_n(rst_n), .bus(bus), .rdata(rdata),
      .pwm_trig(pwm_trig), .core_result(core_result), .ana(ana), .irq_req(irq_req));
   sac_core_model u_sac_core_model (.ana(ana), .value(core_val), .core_result(core_result));
   // ------------------------------------------------------------
   // shared helpers
   // ------------------------------------------------------------
   task automatic wrap_up();
      $display("errors %0d checks %0d", num_errors, tests_run);
      if (num_errors == 0 && tests_run > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   // longest run is about 2000 cycles; a hang trips well past that
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         num_errors++;
         wrap_up();
      end
   end
   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         num_errors++;
         $display("BAD %s expected %h seen %h", name, exp, seen);
      end
   endtask
   // one-cycle write, then let the analog copy catch up
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk);
      bus <= '0;
      @(posedge clk);
      #1;
   endtask
   // data stand only in the cycle after the strobe
   task automatic rchk(input string n, input logic [7:0] a, input logic [7:0] m,
                       input logic [7:0] e);
      @(posedge clk);
      bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge clk);
      bus <= '0;
      #1;
      chk(n, rdata & m, e);
   endtask
   task automatic pulse();
      @(posedge clk);
      pwm_trig <= 1'b1;
      @(posedge clk);
      pwm_trig <= 1'b0;
      @(posedge clk);
      #1;
   endtask
   // counts busy cycles still ahead and converter clocks seen, bounded
   task automatic conv_len(output int n, output int t, output logic irq);
      n = 0;
      t = 0;
      while (ana.conv_active === 1'b1 && n < 5000) begin
         n++;
         if (ana.clk_tick === 1'b1) begin
            t++;
         end
         @(posedge clk);
         #1;
      end
      irq = irq_req;
   endtask
   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task automatic t_reset();
      logic [7:0] regs [8] = '{ADDR_CTRL, ADDR_REF, ADDR_P1CFG, ADDR_P2CFG,
                               ADDR_INTERRUPT_ENABLE_PRIMARY, ADDR_INTERRUPT_ENABLE_SECONDARY, ADDR_IRF2, 8'h10};
      chk("ana_rst", ana, 32'h0);
      chk("irq_rst", irq_req, 32'h0);
      foreach (regs[i]) rchk("reg_rst", regs[i], 8'hff, 8'h00);
      rchk("resl_rst", ADDR_RESL, 8'hf0, 8'h00);
   endtask
   task automatic t_fields();
      wr(ADDR_REF, 8'hfc);
      rchk("ref_rw", ADDR_REF, 8'hff, 8'h94);
      chk("ovr", {ana.ext_ref_en, ana.ref_level}, {1'b1, LVL_VDD});
      wr(ADDR_P1CFG, 8'hff);
      rchk("p1_rw", ADDR_P1CFG, 8'hff, 8'hfe);
      wr(ADDR_P2CFG, 8'hff);
      rchk("p2_rw", ADDR_P2CFG, 8'hff, 8'h3f);
      chk("pure", {ana.p1_pure, ana.p2_pure}, 32'h1fff);
      wr(ADDR_RESL, 8'hff);
      rchk("resl_rw", ADDR_RESL, 8'hf0, 8'hf0);
      // every internal level with the override off
      for (int l = 0; l < 4; l++) begin
         wr(ADDR_REF, l[7:0]);
         chk("level", {ana.ext_ref_en, ana.ref_level}, {1'b0, l[1:0]});
      end
      wr(ADDR_REF, 8'h84);
      // gate open: each code picks one input, reserved codes none
      for (int k = 0; k < 16; k++) begin
         wr(ADDR_CTRL, {4'h0, k[3:0]});
         chk("route", {ana.fixed_sel, ana.opamp_sel, ana.pin_sel},
             (k < 13) ? (32'h1 << k) : 32'h0);
      end
      wr(ADDR_RESL, 8'h00);
      wr(ADDR_CTRL, 8'h03);
      chk("gate_off", {ana.fixed_sel, ana.opamp_sel, ana.pin_sel}, 32'h0);
      // start while disabled is dropped
      wr(ADDR_CTRL, 8'h5f);
      rchk("start_off", ADDR_CTRL, 8'hff, 8'h0f);
      chk("idle", {ana.power_en, ana.conv_active}, 32'h0);
   endtask
   task automatic t_convert(input logic [1:0] code, input int d, input logic ien,
                            input logic [11:0] v);
      int   n;
      int   t;
      logic irq;
      core_val = v;
      wr(ADDR_INTERRUPT_ENABLE_SECONDARY, {6'h00, ien, 1'b0});
      wr(ADDR_RESL, {2'b01, code, 4'h0});
      wr(ADDR_CTRL, 8'hc5);
      conv_len(n, t, irq);
      chk("conv_len", n, CONV_TICKS * d);
      // every converter clock of the run falls inside the window
      chk("conv_ticks", t, CONV_PERIODS * CONV_QUARTER);
      chk("irq_req", irq, ien);
      chk("power", ana.power_en, 32'h1);
      rchk("ctrl_done", ADDR_CTRL, 8'hff, 8'ha5);
      rchk("res_hi", ADDR_RESH, 8'hff, v[11:4]);
      rchk("res_lo", ADDR_RESL, 8'h0f, {4'h0, v[3:0]});
      rchk("irq_flag", ADDR_IRF2, 8'hff, 8'h01);
      wr(ADDR_IRF2, 8'h00);
      chk("irq_clr", irq_req, 32'h0);
   endtask
   task automatic t_trigger();
      int   n;
      int   t;
      logic irq;
      core_val = 12'h3c6;
      wr(ADDR_RESL, 8'h60);
      wr(ADDR_REF, 8'h10);
      wr(ADDR_CTRL, 8'h05);
      pulse();
      chk("pwm_off", ana.conv_active, 32'h0);
      wr(ADDR_CTRL, 8'h85);
      rchk("eoc_clr", ADDR_CTRL, 8'hff, 8'h85);
      wr(ADDR_REF, 8'h00);
      pulse();
      chk("pwm_mask", ana.conv_active, 32'h0);
      wr(ADDR_REF, 8'h10);
      pulse();
      // a second start mid-run must not stretch the conversion
      wr(ADDR_CTRL, 8'hc5);
      rchk("busy", ADDR_CTRL, 8'hff, 8'hc5);
      conv_len(n, t, irq);
      // five busy cycles passed before the count began
      chk("pwm_len", n, CONV_TICKS - 5);
      chk("pwm_ticks", t, CONV_TICKS - 5);
      rchk("pwm_res", ADDR_RESH, 8'hff, 8'h3c);
      // clearing enable mid-run abandons the conversion, no done flag
      wr(ADDR_CTRL, 8'hc5);
      chk("abort_run", ana.conv_active, 32'h1);
      wr(ADDR_CTRL, 8'h00);
      chk("power_off", ana.power_en, 32'h0);
      chk("abort", ana.conv_active, 32'h0);
      rchk("abort_ctl", ADDR_CTRL, 8'hff, 8'h00);
   endtask
   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
      #1;
      t_reset();
      t_fields();
      t_convert(2'h0, 16, 1'b1, 12'h5a3);
      t_convert(2'h1, 8, 1'b0, 12'hc3c);
      t_convert(2'h2, 1, 1'b1, 12'h0f1);
      t_convert(2'h3, 2, 1'b1, 12'hfff);
      t_trigger();
      wrap_up();
   end
endmodule
